// ===== verilog/drx_regs.sv
// Purpose: Dual receive port control register bank with per-port steering
// Assumes: Register port driven by the control-bus target, one access a cycle
// Notes:   Read data is registered and valid the cycle after REG_RD
// Operation
// R01: Bit 7 of the pixel clock test register selects the test clock input as pixel clock.
// R02: With lock mode 0, receive lock is shown only while active video arrives.
// R03: With lock mode 1, receive lock is shown whenever linked to the serializer.
// R04: Raw back-channel mode passes the first remote GPIO unfiltered to the serializer.
// R05: Input mode 00 detects single or dual link from the received data.
// R06: Input mode 01 forces dual, 10 single primary, 11 single secondary.
// R07: With second port select set, writes reach the port 1 copy and shared registers.
// R08: Software clears second port select before reading port 0 copies.
// R09: First port select resets to 1 and steers writes to the port 0 copy too.
// R10: With both selects set, per-port reads return the port 1 copy.
// R11: With second port select set, equalizer test writes go to port 1 controls.
// R12: Equalizer restart is written high then low and restarts adaptation.
// R13: A restart acts on both receive ports whichever port is selected.
// R14: Floor start is honoured only while the floor override bit is set.
// R15: An effective floor start begins adaptation from a preset floor value.
// R16: Video-off at 1 means no active video while control stays operational.
// R17: Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module drx_regs (
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       LINKED,
  input  wire logic       VIDEO_OFF,
  input  wire logic       DET_DUAL,
  input  wire logic       DET_SECONDARY,
  input  wire logic       FIRST_REMOTE_GPIO,
  output logic            PCLK_EXT_SEL,
  output logic            RX_LOCK,
  output logic            BC_RAW_EN,
  output logic            BC_RAW_DATA,
  output logic            DUAL_LINK,
  output logic            SEC_INPUT,
  output logic            EQ_RESTART_P0,
  output logic            EQ_RESTART_P1,
  output logic            EQ_FLOOR_START_P0,
  output logic            EQ_FLOOR_START_P1
);
  logic [7:0] pclk_r;
  logic [7:0] pclk_nxt;
  logic [7:0] dual_r;
  logic [7:0] dual_nxt;
  logic [7:0] eq0_r;
  logic [7:0] eq0_nxt;
  logic [7:0] eq1_r;
  logic [7:0] eq1_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       lock_r;
  logic       lock_nxt;
  logic       bcen_r;
  logic       bcen_nxt;
  logic       bcd_r;
  logic       bcd_nxt;
  logic       dual_o_r;
  logic       dual_o_nxt;
  logic       sec_r;
  logic       sec_nxt;
  logic [1:0] mode;
  logic       sel0;
  logic       sel1;

  drx_eq_if eq_p0 ();
  drx_eq_if eq_p1 ();

  function automatic logic [7:0] wr_field(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [7:0] mask);
    wr_field = (old & ~mask) | (wd & mask); // R17
  endfunction

  assign mode = dual_r[drx_pkg::BIT_MODE_HI:drx_pkg::BIT_MODE_LO];
  assign sel0 = dual_r[drx_pkg::BIT_FIRST_PORT_SELECT];
  assign sel1 = dual_r[drx_pkg::BIT_SECOND_PORT_SELECT];

  // Register writes and steering of the per-port equalizer copy
  always_comb begin
    pclk_nxt = pclk_r;
    dual_nxt = dual_r;
    eq0_nxt  = eq0_r;
    eq1_nxt  = eq1_r;
    if (REG_WR) begin
      case (REG_ADDR)
        drx_pkg::ADDR_PCLK_TEST: begin
          pclk_nxt = wr_field(pclk_r, REG_WDATA, drx_pkg::MASK_PCLK_TEST);
        end
        drx_pkg::ADDR_DUAL_RX: begin
          dual_nxt = wr_field(dual_r, REG_WDATA, drx_pkg::MASK_DUAL_RX);
        end
        drx_pkg::ADDR_EQ_TEST: begin
          if (sel0) begin
            eq0_nxt = wr_field(eq0_r, REG_WDATA, drx_pkg::MASK_EQ_TEST); // R09
          end
          if (sel1) begin
            eq1_nxt = wr_field(eq1_r, REG_WDATA, drx_pkg::MASK_EQ_TEST); // R07 R11
          end
        end
        default: begin
          pclk_nxt = pclk_r;
        end
      endcase
    end
  end

  // Registered read path
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      case (REG_ADDR)
        drx_pkg::ADDR_PCLK_TEST: rdata_nxt = pclk_r;
        drx_pkg::ADDR_DUAL_RX:   rdata_nxt = dual_r;
        drx_pkg::ADDR_EQ_TEST:   rdata_nxt = sel1 ? eq1_r : eq0_r; // R10 R08
        default:                 rdata_nxt = 8'h00;
      endcase
    end
  end

  // Link-facing controls
  always_comb begin
    lock_nxt = LINKED & (dual_r[drx_pkg::BIT_LOCK_MODE] | ~VIDEO_OFF); // R02 R03 R16
    bcen_nxt = dual_r[drx_pkg::BIT_RAW_BC];
    bcd_nxt  = dual_r[drx_pkg::BIT_RAW_BC] & FIRST_REMOTE_GPIO; // R04
    case (mode)
      drx_pkg::MODE_AUTO: begin
        dual_o_nxt = DET_DUAL; // R05
        sec_nxt    = ~DET_DUAL & DET_SECONDARY;
      end
      drx_pkg::MODE_DUAL: begin
        dual_o_nxt = 1'b1; // R06
        sec_nxt    = 1'b0;
      end
      drx_pkg::MODE_SINGLE_P: begin
        dual_o_nxt = 1'b0; // R06
        sec_nxt    = 1'b0;
      end
      default: begin
        dual_o_nxt = 1'b0; // R06
        sec_nxt    = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      pclk_r   <= drx_pkg::RST_PCLK_TEST;
      dual_r   <= drx_pkg::RST_DUAL_RX; // R09
      eq0_r    <= drx_pkg::RST_EQ_TEST;
      eq1_r    <= drx_pkg::RST_EQ_TEST;
      rdata_r  <= 8'h00;
      lock_r   <= 1'b0;
      bcen_r   <= 1'b0;
      bcd_r    <= 1'b0;
      dual_o_r <= 1'b0;
      sec_r    <= 1'b0;
    end else begin
      pclk_r   <= pclk_nxt;
      dual_r   <= dual_nxt;
      eq0_r    <= eq0_nxt;
      eq1_r    <= eq1_nxt;
      rdata_r  <= rdata_nxt;
      lock_r   <= lock_nxt;
      bcen_r   <= bcen_nxt;
      bcd_r    <= bcd_nxt;
      dual_o_r <= dual_o_nxt;
      sec_r    <= sec_nxt;
    end
  end

  // Either copy's restart bit restarts adaptation on both ports
  assign eq_p0.restart_req = eq0_r[drx_pkg::BIT_EQ_RESTART] // R13
                           | eq1_r[drx_pkg::BIT_EQ_RESTART];
  assign eq_p1.restart_req = eq0_r[drx_pkg::BIT_EQ_RESTART] // R13
                           | eq1_r[drx_pkg::BIT_EQ_RESTART];
  assign eq_p0.floor_ovr   = eq0_r[drx_pkg::BIT_FLOOR_OVR];
  assign eq_p0.floor_set   = eq0_r[drx_pkg::BIT_FLOOR_START];
  assign eq_p1.floor_ovr   = eq1_r[drx_pkg::BIT_FLOOR_OVR];
  assign eq_p1.floor_set   = eq1_r[drx_pkg::BIT_FLOOR_START];

  drx_eq_ctl u_eq0 (
    .REF_CLK (REF_CLK),
    .NRST    (NRST),
    .eq      (eq_p0)
  );

  drx_eq_ctl u_eq1 (
    .REF_CLK (REF_CLK),
    .NRST    (NRST),
    .eq      (eq_p1)
  );

  assign REG_RDATA         = rdata_r;
  assign PCLK_EXT_SEL      = pclk_r[drx_pkg::BIT_EXT_PCLK]; // R01
  assign RX_LOCK           = lock_r;
  assign BC_RAW_EN         = bcen_r;
  assign BC_RAW_DATA       = bcd_r;
  assign DUAL_LINK         = dual_o_r;
  assign SEC_INPUT         = sec_r;
  assign EQ_RESTART_P0     = eq_p0.restart_pulse;
  assign EQ_RESTART_P1     = eq_p1.restart_pulse;
  assign EQ_FLOOR_START_P0 = eq_p0.floor_start; // R15
  assign EQ_FLOOR_START_P1 = eq_p1.floor_start; // R15

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_ext_pclk_sel: assert property (REG_WR && REG_ADDR == drx_pkg::ADDR_PCLK_TEST // R01
                                   |=> PCLK_EXT_SEL == $past(REG_WDATA[drx_pkg::BIT_EXT_PCLK]))
    else $error("pixel clock select not taken from write");
  a_lock_video: assert property (!dual_r[drx_pkg::BIT_LOCK_MODE] && VIDEO_OFF |=> !RX_LOCK) // R02
    else $error("lock shown without active video");
  a_lock_linked: assert property (dual_r[drx_pkg::BIT_LOCK_MODE] && LINKED |=> RX_LOCK) // R03
    else $error("lock missing while linked");
  a_raw_bc_pass: assert property (dual_r[drx_pkg::BIT_RAW_BC] // R04
                                  |=> BC_RAW_DATA == $past(FIRST_REMOTE_GPIO))
    else $error("raw back channel data mismatch");
  a_auto_detect: assert property (mode == drx_pkg::MODE_AUTO // R05
                                  |=> DUAL_LINK == $past(DET_DUAL))
    else $error("auto mode ignored detection");
  a_forced_mode: assert property (mode == drx_pkg::MODE_SINGLE_S // R06
                                  |=> SEC_INPUT && !DUAL_LINK)
    else $error("forced secondary single not applied");
  a_port1_write: assert property (REG_WR && REG_ADDR == drx_pkg::ADDR_EQ_TEST && sel1 // R07 R11
                                  |=> eq1_r == ($past(REG_WDATA) & drx_pkg::MASK_EQ_TEST))
    else $error("port 1 copy not written");
  a_port0_guard: assert property (REG_WR && REG_ADDR == drx_pkg::ADDR_EQ_TEST && !sel0 // R09
                                  |=> $stable(eq0_r))
    else $error("port 0 copy written while deselected");
  a_read_port1: assert property (REG_RD && REG_ADDR == drx_pkg::ADDR_EQ_TEST && sel0 && sel1 // R10
                                 |=> REG_RDATA == $past(eq1_r))
    else $error("both selected did not read port 1");
  a_restart_both: assert property (EQ_RESTART_P0 |-> EQ_RESTART_P1) // R13
    else $error("restart reached one port only");
  a_reserved_zero: assert property (REG_RD && REG_ADDR == drx_pkg::ADDR_DUAL_RX // R17
                                    |=> (REG_RDATA & ~drx_pkg::MASK_DUAL_RX) == 8'h00)
    else $error("reserved bits read nonzero");

  c_both_sel_read: cover property (sel0 && sel1 && REG_RD && REG_ADDR == drx_pkg::ADDR_EQ_TEST);
  c_restart_p1:    cover property (EQ_RESTART_P1 && sel1 && !sel0);
  c_floor_start:   cover property (EQ_FLOOR_START_P0 ##1 EQ_RESTART_P0);
endmodule
`default_nettype wire

// ===== inc/drx_pkg.sv
// Purpose: Shared constants for the dual receive port control registers
// Assumes: 8-bit registers reached through an internal register port
// Notes:   Offsets, field positions and reset values live here only
`default_nettype none
package drx_pkg;
  localparam logic [7:0] ADDR_PCLK_TEST = 8'h2E;
  localparam logic [7:0] ADDR_DUAL_RX   = 8'h34;
  localparam logic [7:0] ADDR_EQ_TEST   = 8'h35;

  localparam int BIT_EXT_PCLK     = 7;
  localparam int BIT_LOCK_MODE    = 6;
  localparam int BIT_RAW_BC       = 5;
  localparam int BIT_MODE_HI      = 4;
  localparam int BIT_MODE_LO      = 3;
  localparam int BIT_SECOND_PORT_SELECT    = 1;
  localparam int BIT_FIRST_PORT_SELECT    = 0;
  localparam int BIT_EQ_RESTART   = 6;
  localparam int BIT_FLOOR_OVR    = 5;
  localparam int BIT_FLOOR_START  = 4;

  localparam logic [7:0] MASK_PCLK_TEST = 8'h80;
  localparam logic [7:0] MASK_DUAL_RX   = 8'h7B;
  localparam logic [7:0] MASK_EQ_TEST   = 8'h70;

  localparam logic [7:0] RST_PCLK_TEST = 8'h00;
  localparam logic [7:0] RST_DUAL_RX   = 8'h01;
  localparam logic [7:0] RST_EQ_TEST   = 8'h00;

  localparam logic [1:0] MODE_AUTO     = 2'h0;
  localparam logic [1:0] MODE_DUAL     = 2'h1;
  localparam logic [1:0] MODE_SINGLE_P = 2'h2;
  localparam logic [1:0] MODE_SINGLE_S = 2'h3;

  typedef enum logic [1:0] {
    EQ_IDLE  = 2'h0,
    EQ_PULSE = 2'h1,
    EQ_HOLD  = 2'h3
  } drx_eq_state_t;
endpackage
`default_nettype wire

// ===== inc/drx_eq_if.sv
// Purpose: Carrier between the register bank and one equalizer control slice
// Assumes: One instance per receive port
// Notes:   Restart request is a level that software writes high then low
`timescale 1ns/1ps
`default_nettype none
interface drx_eq_if;
  logic restart_req;
  logic floor_ovr;
  logic floor_set;
  logic restart_pulse;
  logic floor_start;
  modport regs (output restart_req, output floor_ovr, output floor_set,
                input restart_pulse, input floor_start);
  modport ctl  (input restart_req, input floor_ovr, input floor_set,
                output restart_pulse, output floor_start);
endinterface
`default_nettype wire

// ===== verilog/drx_eq_ctl.sv
// Purpose: Equalizer restart and floor control for one receive port
// Assumes: Restart request held high by software until it writes it low again
// Notes:   One restart pulse per rising level; floor start only under override
`timescale 1ns/1ps
`default_nettype none
module drx_eq_ctl (
  input  wire logic REF_CLK,
  input  wire logic NRST,
  drx_eq_if.ctl     eq
);
  drx_pkg::drx_eq_state_t state_r;
  drx_pkg::drx_eq_state_t state_nxt;
  logic                   pulse_r;
  logic                   pulse_nxt;
  logic                   floor_r;
  logic                   floor_nxt;

  always_comb begin
    state_nxt = state_r;
    pulse_nxt = 1'b0;
    floor_nxt = eq.floor_ovr & eq.floor_set; // R14 R15
    case (state_r)
      drx_pkg::EQ_IDLE: begin
        if (eq.restart_req) begin
          state_nxt = drx_pkg::EQ_PULSE;
          pulse_nxt = 1'b1; // R12
        end
      end
      drx_pkg::EQ_PULSE: begin
        state_nxt = eq.restart_req ? drx_pkg::EQ_HOLD : drx_pkg::EQ_IDLE;
      end
      drx_pkg::EQ_HOLD: begin
        if (!eq.restart_req) begin
          state_nxt = drx_pkg::EQ_IDLE; // R12
        end
      end
      default: begin
        state_nxt = drx_pkg::EQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_r <= drx_pkg::EQ_IDLE;
      pulse_r <= 1'b0;
      floor_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pulse_r <= pulse_nxt;
      floor_r <= floor_nxt;
    end
  end

  assign eq.restart_pulse = pulse_r;
  assign eq.floor_start   = floor_r;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_restart_once: assert property (eq.restart_pulse |=> !eq.restart_pulse) // R12
    else $error("restart pulse longer than one cycle");
  a_restart_rise: assert property ($rose(eq.restart_req) && state_r == drx_pkg::EQ_IDLE
                                   |=> eq.restart_pulse) // R12
    else $error("restart request did not pulse");
  a_floor_gate: assert property (!$past(eq.floor_ovr) |-> !eq.floor_start) // R14
    else $error("floor start without override");
  c_restart: cover property (eq.restart_pulse ##[1:20] !eq.restart_req);
endmodule
`default_nettype wire

// ===== tb/drx_regs_tb_top.sv
// Purpose: Self-checking bench for the dual receive port control register bank
// Assumes: Register port write effect one cycle late, read data one cycle after REG_RD
// Notes:   Inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module drx_regs_tb_top;
  logic       clk = 1'b0;
  logic       nrst;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       linked;
  logic       video_off;
  logic       det_dual;
  logic       det_sec;
  logic       gpio;
  logic       pclk_ext_sel;
  logic       rx_lock;
  logic       bc_raw_en;
  logic       bc_raw_data;
  logic       dual_link;
  logic       sec_input;
  logic       rst_p0;
  logic       rst_p1;
  logic       floor_p0;
  logic       floor_p1;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  drx_regs i_drx_regs (
    .REF_CLK           (clk),
    .NRST              (nrst),
    .REG_WR            (reg_wr),
    .REG_RD            (reg_rd),
    .REG_ADDR          (reg_addr),
    .REG_WDATA         (reg_wdata),
    .REG_RDATA         (reg_rdata),
    .LINKED            (linked),
    .VIDEO_OFF         (video_off),
    .DET_DUAL          (det_dual),
    .DET_SECONDARY     (det_sec),
    .FIRST_REMOTE_GPIO (gpio),
    .PCLK_EXT_SEL      (pclk_ext_sel),
    .RX_LOCK           (rx_lock),
    .BC_RAW_EN         (bc_raw_en),
    .BC_RAW_DATA       (bc_raw_data),
    .DUAL_LINK         (dual_link),
    .SEC_INPUT         (sec_input),
    .EQ_RESTART_P0     (rst_p0),
    .EQ_RESTART_P1     (rst_p1),
    .EQ_FLOOR_START_P0 (floor_p0),
    .EQ_FLOOR_START_P1 (floor_p1)
  );

  always #25 clk = ~clk;

  task automatic finish_test();
    $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, exp, "read data");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Counts restart pulses on both ports over a short window
  task automatic pulses(input logic [7:0] exp);
    logic [7:0] c0;
    logic [7:0] c1;
    c0 = 8'h00;
    c1 = 8'h00;
    repeat (6) begin
      #1;
      if (rst_p0 === 1'b1) c0++;
      if (rst_p1 === 1'b1) c1++;
      @(posedge clk);
    end
    cmp8(c0, exp, "restart pulses port 0");
    cmp8(c1, exp, "restart pulses port 1");
  endtask

  task automatic t_reset();
    chk_rd(8'h2E, 8'h00);
    chk_rd(8'h34, 8'h01);
    chk_rd(8'h35, 8'h00);
    cmp1(pclk_ext_sel, 1'b0, "ext clock after reset");
    cmp1(floor_p0, 1'b0, "floor start after reset");
  endtask

  task automatic t_reserved();
    wr(8'h2E, 8'hFF);
    chk_rd(8'h2E, 8'h80);
    settle();
    cmp1(pclk_ext_sel, 1'b1, "ext clock select");
    wr(8'h2E, 8'h00);
    settle();
    cmp1(pclk_ext_sel, 1'b0, "ext clock deselect");
    wr(8'h34, 8'h85);
    chk_rd(8'h34, 8'h01);
    wr(8'h35, 8'h8F);
    chk_rd(8'h35, 8'h00);
    wr(8'h40, 8'hFF);
    chk_rd(8'h40, 8'h00);
  endtask

  task automatic t_lock();
    @(posedge clk);
    linked    <= 1'b1;
    video_off <= 1'b1;
    settle();
    cmp1(rx_lock, 1'b0, "lock with video off");
    @(posedge clk);
    video_off <= 1'b0;
    settle();
    cmp1(rx_lock, 1'b1, "lock with video");
    @(posedge clk);
    video_off <= 1'b1;
    wr(8'h34, 8'h41);
    settle();
    cmp1(rx_lock, 1'b1, "link-only lock");
    @(posedge clk);
    linked <= 1'b0;
    settle();
    cmp1(rx_lock, 1'b0, "lock without link");
    wr(8'h34, 8'h01);
  endtask

  task automatic t_raw();
    wr(8'h34, 8'h21);
    gpio <= 1'b1;
    settle();
    cmp1(bc_raw_en, 1'b1, "raw mode enable");
    cmp1(bc_raw_data, 1'b1, "raw data high");
    @(posedge clk);
    gpio <= 1'b0;
    settle();
    cmp1(bc_raw_data, 1'b0, "raw data low");
    @(posedge clk);
    gpio <= 1'b1;
    wr(8'h34, 8'h01);
    settle();
    cmp1(bc_raw_en, 1'b0, "raw mode off");
    cmp1(bc_raw_data, 1'b0, "raw data held low when off");
  endtask

  task automatic t_modes();
    // Row: mode, then detector dual/secondary, then expected dual/secondary
    logic [5:0] tbl [5] = '{6'b00_0101, 6'b00_1010, 6'b01_0010, 6'b10_1100, 6'b11_1001};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      det_dual <= tbl[i][3];
      det_sec  <= tbl[i][2];
      wr(8'h34, {3'b000, tbl[i][5:4], 3'b001});
      settle();
      cmp1(dual_link, tbl[i][1], "dual link");
      cmp1(sec_input, tbl[i][0], "secondary input");
    end
    wr(8'h34, 8'h01);
  endtask

  task automatic t_steer();
    wr(8'h35, 8'h30);
    settle();
    cmp1(floor_p0, 1'b1, "floor start port 0");
    cmp1(floor_p1, 1'b0, "floor start port 1 untouched");
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h10);
    settle();
    cmp1(floor_p1, 1'b0, "floor start without override");
    cmp1(floor_p0, 1'b1, "port 0 kept");
    chk_rd(8'h35, 8'h10);
    wr(8'h34, 8'h00);
    chk_rd(8'h35, 8'h30);
    wr(8'h34, 8'h03);
    chk_rd(8'h35, 8'h10);
    wr(8'h35, 8'h20);
    chk_rd(8'h35, 8'h20);
    wr(8'h34, 8'h01);
    chk_rd(8'h35, 8'h20);
    settle();
    cmp1(floor_p0, 1'b0, "override alone port 0");
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h30);
    settle();
    cmp1(floor_p1, 1'b1, "floor start port 1");
    wr(8'h35, 8'h00);
  endtask

  task automatic t_restart();
    wr(8'h35, 8'h40);
    pulses(8'h01);
    wr(8'h35, 8'h40);
    pulses(8'h00);
    wr(8'h35, 8'h00);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h40);
    pulses(8'h01);
    wr(8'h35, 8'h00);
    pulses(8'h00);
  endtask

  initial begin
    nrst      = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    linked    = 1'b0;
    video_off = 1'b0;
    det_dual  = 1'b0;
    det_sec   = 1'b0;
    gpio      = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_reserved();
    t_lock();
    t_raw();
    t_modes();
    t_steer();
    t_restart();
    finish_test();
  end
endmodule
`default_nettype wire
